// ---- core/pwm_out_pkg.sv ----
package pwm_out_pkg;
	// register indices on the plain register port
	localparam logic [3:0] ctrl_addr     = 4'h0;
	localparam logic [3:0] key_addr      = 4'h1;
	localparam logic [3:0] config_addr   = 4'h2;
	localparam logic [3:0] status_addr   = 4'h3;
	// control and config register field positions, reset values and keys
	localparam int ovr_dat_lsb  = 6;
	localparam int flt_dat_lsb  = 4;
	localparam int cl_dat_lsb   = 2;
	localparam int swap_bit     = 1;
	localparam int flt_mod_lsb  = 16;
	localparam int cl_mod_bit   = 24;
	localparam int ovr_enl_bit  = 8;
	localparam int ovr_enh_bit  = 9;
	localparam int pol_l_bit    = 12;
	localparam int pol_h_bit    = 13;
	localparam int pen_l_bit    = 14;
	localparam int pen_h_bit    = 15;
	localparam int flt_src_lsb  = 0;
	localparam int cl_src_lsb   = 4;
	localparam int dtc_lsb      = 8;
	localparam int time_base_enable_bit     = 12;
	localparam logic [31:0] ctrl_reset   = 32'h0000_0000;
	localparam logic [31:0] config_reset = 32'h0000_0000;
	localparam logic [15:0] key_first    = 16'hABCD;
	localparam logic [15:0] key_second   = 16'h4321;
	localparam logic [1:0]  dtc_fault3   = 2'h3;
	localparam int          fault_pins   = 16;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [3:0] addr;
		logic [31:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic high;
		logic low;
	} pin_pair_t;
endpackage

// ---- core/pwm_key_unlock.sv ----
`timescale 1ns/10ps
// key sequencer: unlocked only for the access straight after both keys
module pwm_key_unlock (
	input  wire logic                 sys_clk,
	input  wire logic                 resetn,
	input  wire pwm_out_pkg::reg_req_t req,
	output logic                      unlocked
);
	typedef enum logic [1:0] {idle_s, first_s, open_s} key_state_t;
	key_state_t state_q, state_d;
	logic       key_wr;

	assign key_wr   = req.wr && req.addr == pwm_out_pkg::key_addr;
	assign unlocked = state_q == open_s;

	// any access other than the expected next one drops the sequence; a first key write restarts it at first_s
	always_comb begin
		state_d = state_q;
		if (req.wr || req.rd) begin
			unique case (state_q)
				idle_s: state_d = (key_wr && req.wdata[15:0] == pwm_out_pkg::key_first)
					? first_s : idle_s;
				first_s: state_d = (key_wr && req.wdata[15:0] == pwm_out_pkg::key_second)
					? open_s : ((key_wr && req.wdata[15:0] == pwm_out_pkg::key_first)
					? first_s : idle_s);
				open_s: state_d = (key_wr && req.wdata[15:0] == pwm_out_pkg::key_first)
					? first_s : idle_s;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			state_q <= idle_s;
		end else begin
			state_q <= state_d;
		end
	end

	open_one_access_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		unlocked && (req.wr || req.rd) |=> !unlocked) else $error("unlock outlived access");
	two_keys_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		$rose(unlocked) |-> $past(key_wr) && $past(req.wdata[15:0]) == 16'h4321)
		else $error("unlock without second key");
endmodule

// ---- core/pwm_pin_output_override.sv ----
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/10ps
// Summary of operation
// - with override enabled per side and no active fault or limit, the high pin takes override bit 7 and the low pin bit 6.
// - in fault mode 00 or 01 with an active fault, pins take fault data bits 5 and 4.
// - with no active fault the fault data bits have no effect on the pins.
// - with current-limit mode at bit 24, an active limit and no active fault, pins take data bits 3 and 2.
// - the swap bit exchanges which PWM signal drives which pin.
// - forced data are active states turned into pin levels by the polarity bits.
// - when write protection holds, control writes need keys ABCD then 4321 first.
// - the protected write must be the very next access after the keys, else it is dropped.
// - with pin-enable bits low the general port keeps both pins.
// - compensation select 11 connects the compensation input to fault pin 3.
// - fault source code 0111 picks fault pin 8 and code 0010 picks fault pin 3.
module pwm_pin_output_override (
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic        write_protect_config,
	input  wire logic        pwm_high_in,
	input  wire logic        pwm_low_in,
	input  wire logic [15:0] shared_fault_input,
	output logic             high_side_output,
	output logic             low_side_output,
	output logic             high_pin_own,
	output logic             low_pin_own,
	output logic             dead_time_comp_input
);
	pwm_out_pkg::reg_req_t  req;
	logic [31:0]            ctrl_q, ctrl_d, cfg_q, cfg_d, rdata_q, rdata_d;
	logic [15:0]            fault_s1_q, fault_s2_q;
	logic                   unlocked;
	logic                   fault_act, cl_act;
	logic [3:0]             flt_src, cl_src;
	logic [1:0]             flt_mod, dead_time_comp_select;
	pwm_out_pkg::pin_pair_t forced, routed, pins_d, pins_q;
	logic                   own_h_q, own_l_q, dtc_q, dtc_d;

	assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

	pwm_key_unlock u_key (
		.sys_clk  (sys_clk),
		.resetn   (resetn),
		.req      (req),
		.unlocked (unlocked)
	);

	// fault pins are asynchronous to the clock, two flops before use
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			fault_s1_q <= 16'h0000;
			fault_s2_q <= 16'h0000;
		end else begin
			fault_s1_q <= shared_fault_input;
			fault_s2_q <= fault_s1_q;
		end
	end

	// lock config 0 means protected; a dropped write simply does not land
	always_comb begin
		ctrl_d = ctrl_q;
		cfg_d  = cfg_q;
		if (reg_wr && reg_addr == pwm_out_pkg::ctrl_addr &&
		    (write_protect_config || unlocked)) begin
			ctrl_d = reg_wdata;
			// fault data are frozen while the time base runs, old bits kept
			if (cfg_q[pwm_out_pkg::time_base_enable_bit])
				ctrl_d[pwm_out_pkg::flt_dat_lsb +: 2] = ctrl_q[pwm_out_pkg::flt_dat_lsb +: 2];
		end
		if (reg_wr && reg_addr == pwm_out_pkg::config_addr)
			cfg_d = reg_wdata;
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			ctrl_q <= pwm_out_pkg::ctrl_reset;
			cfg_q  <= pwm_out_pkg::config_reset;
		end else begin
			ctrl_q <= ctrl_d;
			cfg_q  <= cfg_d;
		end
	end

	// fault and limit source decode; code n selects fault pin n+1
	assign flt_src   = cfg_q[pwm_out_pkg::flt_src_lsb +: 4];
	assign cl_src    = cfg_q[pwm_out_pkg::cl_src_lsb +: 4];
	assign dead_time_comp_select       = cfg_q[pwm_out_pkg::dtc_lsb +: 2];
	assign flt_mod   = ctrl_q[pwm_out_pkg::flt_mod_lsb +: 2];
	assign fault_act = (flt_mod == 2'h0 || flt_mod == 2'h1) && fault_s2_q[flt_src];
	assign cl_act    = ctrl_q[pwm_out_pkg::cl_mod_bit] && fault_s2_q[cl_src];

	// swap, then priority chain, then polarity
	always_comb begin
		routed.high = ctrl_q[pwm_out_pkg::swap_bit] ? pwm_low_in : pwm_high_in;
		routed.low  = ctrl_q[pwm_out_pkg::swap_bit] ? pwm_high_in : pwm_low_in;
		forced = routed;
		if (fault_act) begin
			forced.high = ctrl_q[pwm_out_pkg::flt_dat_lsb + 1];
			forced.low  = ctrl_q[pwm_out_pkg::flt_dat_lsb];
		end else if (cl_act) begin
			forced.high = ctrl_q[pwm_out_pkg::cl_dat_lsb + 1];
			forced.low  = ctrl_q[pwm_out_pkg::cl_dat_lsb];
		end else begin
			if (ctrl_q[pwm_out_pkg::ovr_enh_bit])
				forced.high = ctrl_q[pwm_out_pkg::ovr_dat_lsb + 1];
			if (ctrl_q[pwm_out_pkg::ovr_enl_bit])
				forced.low = ctrl_q[pwm_out_pkg::ovr_dat_lsb];
		end
		// polarity 1 means active low at the pin
		pins_d.high = forced.high ^ ctrl_q[pwm_out_pkg::pol_h_bit];
		pins_d.low  = forced.low ^ ctrl_q[pwm_out_pkg::pol_l_bit];
		dtc_d = (dead_time_comp_select == pwm_out_pkg::dtc_fault3) ? fault_s2_q[2] : 1'b0;
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			pins_q  <= '0;
			own_h_q <= 1'b0;
			own_l_q <= 1'b0;
			dtc_q   <= 1'b0;
		end else begin
			pins_q  <= pins_d;
			own_h_q <= ctrl_q[pwm_out_pkg::pen_h_bit];
			own_l_q <= ctrl_q[pwm_out_pkg::pen_l_bit];
			dtc_q   <= dtc_d;
		end
	end

	assign high_side_output     = pins_q.high;
	assign low_side_output      = pins_q.low;
	assign high_pin_own         = own_h_q;
	assign low_pin_own          = own_l_q;
	assign dead_time_comp_input = dtc_q;

	// readback: data the cycle after the read strobe, zero elsewhere
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (reg_rd) begin
			unique case (reg_addr)
				pwm_out_pkg::ctrl_addr:   rdata_d = ctrl_q;
				pwm_out_pkg::config_addr: rdata_d = cfg_q;
				pwm_out_pkg::status_addr: rdata_d = {28'h000_0000, unlocked, cl_act,
					fault_act, pins_q.high};
				default:                  rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

	// write protection: a control write without the keys must leave the register alone
	locked_write_drop_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		reg_wr && reg_addr == 4'h0 && !write_protect_config && !unlocked
		|=> $stable(ctrl_q)) else $error("locked write landed");

	open_write_lands_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		reg_wr && reg_addr == 4'h0 && write_protect_config && !cfg_q[12]
		|=> ctrl_q == $past(reg_wdata)) else $error("open write lost");

	// the key walk, step by step; software may leave idle cycles between the steps
	sequence first_key_s;
		reg_wr && reg_addr == pwm_out_pkg::key_addr
			&& reg_wdata[15:0] == pwm_out_pkg::key_first;
	endsequence

	sequence second_key_s;
		reg_wr && reg_addr == pwm_out_pkg::key_addr
			&& reg_wdata[15:0] == pwm_out_pkg::key_second;
	endsequence

	sequence no_access_s;
		!reg_wr && !reg_rd;
	endsequence

	sequence other_read_s;
		reg_rd;
	endsequence

	sequence guarded_write_s;
		reg_wr && reg_addr == pwm_out_pkg::ctrl_addr && !write_protect_config
			&& !cfg_q[pwm_out_pkg::time_base_enable_bit];
	endsequence

	sequence key_pair_s;
		first_key_s ##1 no_access_s ##1 second_key_s;
	endsequence

	keyed_write_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		key_pair_s ##1 no_access_s ##1 guarded_write_s |=> ctrl_q == $past(reg_wdata))
		else $error("keyed write lost");

	// a read slipped in after the keys spends the unlock, so the write must drop
	broken_unlock_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		key_pair_s ##1 no_access_s ##1 other_read_s ##1 no_access_s ##1 guarded_write_s
		|=> $stable(ctrl_q)) else $error("write landed after broken unlock");

	fault_data_frozen_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		reg_wr && reg_addr == 4'h0 && cfg_q[12]
		|=> ctrl_q[5:4] == $past(ctrl_q[5:4])) else $error("fault data changed while running");

	// pin path checks; outputs lag the decision by one register stage
	fault_drives_pins_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		fault_act |=> high_side_output == ($past(ctrl_q[5]) ^ $past(ctrl_q[13])))
		else $error("fault data not on high pin");

	fault_mode_off_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		ctrl_q[17] |-> !fault_act) else $error("fault active in disabled mode");

	fault_over_limit_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		fault_act && cl_act |=> low_side_output == ($past(ctrl_q[4]) ^ $past(ctrl_q[12])))
		else $error("limit beat fault");

	limit_drives_low_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		!fault_act && cl_act |=> low_side_output == ($past(ctrl_q[2]) ^ $past(ctrl_q[12])))
		else $error("limit data not on low pin");

	limit_mode_off_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		!ctrl_q[24] |-> !cl_act) else $error("limit active with mode off");

	override_high_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		!fault_act && !cl_act && ctrl_q[9]
		|=> high_side_output == ($past(ctrl_q[7]) ^ $past(ctrl_q[13])))
		else $error("override high wrong");

	override_low_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		!fault_act && !cl_act && ctrl_q[8]
		|=> low_side_output == ($past(ctrl_q[6]) ^ $past(ctrl_q[12])))
		else $error("override low wrong");

	swap_route_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		!fault_act && !cl_act && !ctrl_q[8] && ctrl_q[1]
		|=> low_side_output == ($past(pwm_high_in) ^ $past(ctrl_q[12])))
		else $error("swap routing wrong");

	swap_high_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		!fault_act && !cl_act && !ctrl_q[9] && ctrl_q[1]
		|=> high_side_output == ($past(pwm_low_in) ^ $past(ctrl_q[13])))
		else $error("swap high routing wrong");

	no_fault_pass_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		!fault_act && !cl_act && ctrl_q[9:8] == 2'h0 && !ctrl_q[1]
		|=> high_side_output == ($past(pwm_high_in) ^ $past(ctrl_q[13])))
		else $error("fault data leaked");

	// ownership and shared fault input routing
	pin_owner_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		!ctrl_q[15] |=> !high_pin_own) else $error("pin taken without enable");

	low_owner_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		!ctrl_q[14] |=> !low_pin_own) else $error("low pin taken without enable");

	dtc_route_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		cfg_q[9:8] == 2'h3 |=> dead_time_comp_input == $past(fault_s2_q[2]))
		else $error("compensation not on fault pin 3");

	dtc_off_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		cfg_q[9:8] != 2'h3 |=> !dead_time_comp_input)
		else $error("compensation routed while unselected");

	fault_source_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		cfg_q[3:0] == 4'h7 && ctrl_q[17] == 1'b0 |-> fault_act == fault_s2_q[7])
		else $error("fault source decode wrong");

	fault_src_three_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		cfg_q[3:0] == 4'h2 && ctrl_q[17] == 1'b0 |-> fault_act == fault_s2_q[2])
		else $error("fault source pin 3 decode wrong");

	// read data stand for one cycle only, so software never sees a stale word
	read_idle_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		!reg_rd |=> reg_rdata == 32'h0000_0000) else $error("read data outside read slot");
endmodule

// ---- bench/pwm_power_stage.sv ----
`timescale 1ns/10ps
// half bridge behind the two pins; an unowned or idle node floats
module pwm_power_stage (
	input  wire logic sys_clk,
	input  wire logic gate_high,
	input  wire logic gate_low,
	input  wire logic own_high,
	input  wire logic own_low,
	output logic      phase_q
);
	// a floating node toggles so a stale level never passes for a driven one
	always_ff @(posedge sys_clk) begin
		if (own_high && gate_high) phase_q <= 1'b1;
		else if (own_low && gate_low) phase_q <= 1'b0;
		else phase_q <= ~phase_q;
	end
endmodule

// ---- bench/test_pwm_pin_output_override.sv ----
`timescale 1ns/10ps
module test_pwm_pin_output_override;
	logic        sys_clk, resetn, reg_wr, reg_rd, wpc, ph_in, pl_in, hs, ls, ho, lo, dead_time_comp_select, phase;
	logic [3:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, v;
	logic [15:0] flt;
	int          error_cnt, checked;
	localparam logic [3:0] ca = pwm_out_pkg::ctrl_addr;
	localparam logic [3:0] ka = pwm_out_pkg::key_addr;
	localparam logic [3:0] fa = pwm_out_pkg::config_addr;

	pwm_pin_output_override u_pwm_pin_output_override (.sys_clk(sys_clk), .resetn(resetn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .write_protect_config(wpc), .pwm_high_in(ph_in),
		.pwm_low_in(pl_in), .shared_fault_input(flt), .high_side_output(hs),
		.low_side_output(ls), .high_pin_own(ho), .low_pin_own(lo), .dead_time_comp_input(dead_time_comp_select));
	pwm_power_stage u_pwm_power_stage (.sys_clk(sys_clk), .gate_high(hs), .gate_low(ls),
		.own_high(ho), .own_low(lo), .phase_q(phase));

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe, so sample mid-cycle there
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		d = reg_rdata;
	endtask

	// fault pins pass a two-flop synchroniser, so allow a few cycles to settle
	task automatic settle;
		repeat (6) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask

	// fault pins change on a rising edge like the register and PWM inputs
	task automatic fault_pins(input logic [15:0] f);
		@(posedge sys_clk);
		flt <= f;
	endtask

	task automatic pins(input string what, input logic [1:0] exp);
		settle();
		chk(what, {30'h0, exp}, {30'h0, hs, ls});
	endtask

	task automatic key;
		wr(ka, {16'h0000, pwm_out_pkg::key_first});
		wr(ka, {16'h0000, pwm_out_pkg::key_second});
	endtask

	// control word: limit mode on, both overrides on, data ovr 11 flt 10 lim 01
	function automatic logic [31:0] fc(input logic [1:0] m);
		return {7'h00, 1'b1, 6'h00, m, 8'h03, 8'hE4};
	endfunction

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk);
		error_cnt++;
		print_verdict();
	end

	initial begin
		{resetn, reg_wr, reg_rd, wpc, ph_in, pl_in} = 6'h00;
		reg_addr = 4'h0;
		reg_wdata = 32'h0000_0000;
		flt = 16'h0000;
		repeat (5) @(posedge sys_clk);
		resetn <= 1'b1;
		rd(ca, v);
		chk("ctrl reset", pwm_out_pkg::ctrl_reset, v);
		rd(4'hF, v);
		chk("unmapped", 32'h0000_0000, v);
		wr(ca, 32'h0000_0002);
		rd(ca, v);
		chk("locked write", 32'h0000_0000, v);
		key();
		wr(ca, 32'h0000_0002);
		rd(ca, v);
		chk("unlocked write", 32'h0000_0002, v);
		key();
		rd(pwm_out_pkg::status_addr, v);
		chk("status unlocked", 32'h0000_0008, v);
		wr(ca, 32'h0000_0000);
		rd(ca, v);
		chk("broken unlock", 32'h0000_0002, v);
		$display("test lock done");
		wpc <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			@(posedge sys_clk);
			ph_in <= i[0];
			pl_in <= i[1];
			wr(ca, {16'h0000, i[3], i[2], i[3], i[3], 10'h000, i[2], 1'b0});
			pins("pwm path", {(i[2] ? i[1] : i[0]) ^ i[3], (i[2] ? i[0] : i[1]) ^ i[3]});
			chk("owner", {30'h0, i[3], i[2]}, {30'h0, ho, lo});
		end
		$display("test swap done");
		@(posedge sys_clk);
		ph_in <= 1'b1;
		pl_in <= 1'b0;
		for (int j = 0; j < 4; j++) begin
			wr(ca, {16'h0000, 8'hA3, j[1:0], 6'h00});
			pins("override", {~j[1], j[0]});
			if (!j[1])
				chk("stage high", 32'h0000_0001, {31'h0, phase});
		end
		$display("test override done");
		wr(fa, 32'h0000_0002);
		wr(ca, fc(2'h0));
		pins("idle data", 2'b11);
		fault_pins(16'h0004);
		for (int m = 0; m < 4; m++) begin
			wr(ca, fc(m[1:0]));
			pins("fault mode", (m < 2) ? 2'b10 : 2'b11);
		end
		wr(fa, 32'h0000_0062);
		rd(fa, v);
		chk("config", 32'h0000_0062, v);
		fault_pins(16'h0044);
		pins("limit", 2'b01);
		wr(ca, fc(2'h0));
		pins("fault over limit", 2'b10);
		wr(fa, 32'h0000_0007);
		fault_pins(16'h0080);
		pins("src 0111", 2'b10);
		fault_pins(16'h0004);
		pins("src other", 2'b11);
		$display("test fault done");
		wr(fa, 32'h0000_0300);
		settle();
		chk("comp on", 32'h0000_0001, {31'h0, dead_time_comp_select});
		wr(fa, 32'h0000_0200);
		settle();
		chk("comp off", 32'h0000_0000, {31'h0, dead_time_comp_select});
		wr(ca, fc(2'h0) | 32'h0000_C000);
		wr(fa, 32'h0000_1000);
		wr(ca, 32'h0000_0010);
		rd(ca, v);
		chk("fault data held", 32'h0000_0020, v);
		$display("test misc done");
		print_verdict();
	end
endmodule
